// *** rtl/srw_pkg.sv ***
// Package for the supervisor reset and watchdog sequencer.
// Assumes a single 25 MHz oscillator clock and digital comparator status inputs.
// Operation
// - Reset output low while any supply, aux or manual reset input is bad.
// - After all inputs good, hold reset low for full hold time.
// - Hold time is a build option from six documented windows.
// - A new failure during hold restarts the hold timer from zero.
// - Manual reset low asserts reset, clears watchdog, keeps alarm high.
// - Alarm goes low when no kick edge within active watchdog period.
// - After every reset event watchdog starts in long mode, 35 s minimum.
// - Switch to short mode on long expiry or first kick edge.
// - Each kick edge restarts short period; missing edge raises alarm.
// - Alarm fed to manual reset forces reset, then clears counter and alarm.
// - Watchdog restarts in long mode when hold period ends.
// - Threshold pair is a build option; comparators give digital status only.
// - Watchdog timer clears while reset asserted and on each kick edge.
// - Alarm asserts during undervoltage lockout, releases without hold delay.
package srw_pkg;
    localparam int CLK_HZ = 25_000_000;
    // Timebase tick every 1 ms
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    // Hold time options, minimum of each window in microseconds
    localparam int HOLD_D1_US = 1100;
    localparam int HOLD_D2_US = 8800;
    localparam int HOLD_D3_US = 140_000;
    localparam int HOLD_D5_US = 280_000;
    localparam int HOLD_D6_US = 560_000;
    localparam int HOLD_D4_US = 1_120_000;
    // Watchdog minimum periods in milliseconds
    localparam int LONG_DOG_MS = 35_000;
    localparam int SHORT_DOG_MS = 1120;
    // Hold least time rounds up to whole ticks; watchdog periods divide exactly
    localparam int HOLD_D3_TICKS = (HOLD_D3_US + TICK_US - 1) / TICK_US;
    localparam int LONG_DOG_TICKS = LONG_DOG_MS * 1000 / TICK_US;
    localparam int SHORT_DOG_TICKS = SHORT_DOG_MS * 1000 / TICK_US;
    localparam int CNT_W = 16;
    // Supply status bundle from the analog comparators
    typedef struct packed {
        logic primary_supply_ok;
        logic secondary_supply_ok;
        logic aux_voltage_ok;
    } srw_supply_t;
    typedef enum logic {SRW_LONG, SRW_SHORT} srw_mode_t;
endpackage : srw_pkg

// *** rtl/srw_sync.sv ***
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk.
module srw_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic din,
    output logic dout
);
    logic meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : srw_sync

// *** rtl/srw_top.sv ***
// Reset sequencer and dual-mode watchdog of a processor supervisor.
// Assumes supply status inputs are synchronous digital levels; kick and
// manual reset come from outside and are synchronised here.
module srw_top
    import srw_pkg::*;
#(
    parameter int TICK_CYC = srw_pkg::TICK_CYCLES,
    parameter int HOLD_TICKS = srw_pkg::HOLD_D3_TICKS,
    parameter int LONG_TICKS = srw_pkg::LONG_DOG_TICKS,
    parameter int SHORT_TICKS = srw_pkg::SHORT_DOG_TICKS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire srw_pkg::srw_supply_t supply,
    input wire logic manual_reset_n,
    input wire logic dog_kick_in,
    output logic reset_out_n,
    output logic dog_alarm_n,
    output srw_pkg::srw_mode_t dog_mode
);
    import srw_pkg::*;

    logic mr_n;
    logic kick_s;
    logic kick_d;
    logic kick_edge;
    logic supply_good;
    logic fault;
    logic tick;
    logic [31:0] pre_cnt;
    logic [31:0] hold_cnt;
    logic [31:0] dog_cnt;
    logic holding;
    logic dog_limit_hit;

    srw_sync #(.RESET_VAL(1'b1)) u_mr_sync (
        .clk(clk),
        .nrst(nrst),
        .din(manual_reset_n),
        .dout(mr_n)
    );
    srw_sync #(.RESET_VAL(1'b0)) u_kick_sync (
        .clk(clk),
        .nrst(nrst),
        .din(dog_kick_in),
        .dout(kick_s)
    );

    // Fault condition and kick edge in either direction
    assign supply_good = supply.primary_supply_ok & supply.secondary_supply_ok
        & supply.aux_voltage_ok;
    assign fault = !supply_good || !mr_n;
    assign kick_edge = kick_s ^ kick_d;
    assign holding = hold_cnt < HOLD_TICKS;
    assign dog_limit_hit = tick && (dog_cnt + 32'h1 >= ((dog_mode == SRW_LONG) ?
        32'(LONG_TICKS) : 32'(SHORT_TICKS)));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kick_d <= 1'b0;
        end else begin
            kick_d <= kick_s;
        end
    end

    // Prescaler gives one tick per period. It restarts on a fault and on an
    // accepted kick, so a hold or watchdog period never ends a tick short.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_cnt <= 32'h0;
            tick <= 1'b0;
        end else if (fault || (kick_edge && !holding)) begin
            pre_cnt <= 32'h0;
            tick <= 1'b0;
        end else if (pre_cnt >= 32'(TICK_CYC - 1)) begin
            pre_cnt <= 32'h0;
            tick <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 32'h1;
            tick <= 1'b0;
        end
    end

    // Hold timer: zero on any fault, counts ticks after all inputs good.
    // The prescaler restarts with it, so the hold never ends a tick short.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_cnt <= 32'h0;
        end else if (fault) begin
            hold_cnt <= 32'h0;
        end else if (holding && tick) begin
            hold_cnt <= hold_cnt + 32'h1;
        end
    end

    // Reset output registered from the fault and hold state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reset_out_n <= 1'b0;
        end else begin
            reset_out_n <= !fault && !holding;
        end
    end

    // Watchdog counter and mode; cleared while reset is asserted
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dog_cnt <= 32'h0;
            dog_mode <= SRW_LONG;
        end else if (fault || holding) begin
            dog_cnt <= 32'h0;
            dog_mode <= SRW_LONG;
        end else if (kick_edge) begin
            dog_cnt <= 32'h0;
            dog_mode <= SRW_SHORT;
        end else if (dog_limit_hit) begin
            dog_cnt <= 32'h0;
            dog_mode <= SRW_SHORT;
        end else if (tick) begin
            dog_cnt <= dog_cnt + 32'h1;
        end
    end

    // Alarm: low on timeout or lockout; manual reset forces it high.
    // Lockout release needs no hold delay, unlike the reset output.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dog_alarm_n <= 1'b1;
        end else if (!mr_n) begin
            dog_alarm_n <= 1'b1;
        end else if (!supply_good) begin
            dog_alarm_n <= 1'b0;
        end else if (holding) begin
            dog_alarm_n <= 1'b1;
        end else if (kick_edge) begin
            dog_alarm_n <= 1'b1;
        end else if (dog_limit_hit) begin
            dog_alarm_n <= 1'b0;
        end else if (dog_alarm_n == 1'b0 && supply_good && dog_cnt == 32'h0 &&
            !tick && dog_mode == SRW_SHORT) begin
            dog_alarm_n <= 1'b0;
        end
    end

    // Reset output follows any fault one cycle later
    AST_FAULT_RESET: assert property (@(posedge clk) disable iff (!nrst)
        fault |=> !reset_out_n)
        else $error("reset not asserted on fault");

    // Reset stays low for as long as the hold timer runs
    AST_HOLD_KEEPS: assert property (@(posedge clk) disable iff (!nrst)
        (holding && !fault) |=> !reset_out_n)
        else $error("reset released early");

    // A fault during the hold throws away the time already counted
    AST_HOLD_RESTART: assert property (@(posedge clk) disable iff (!nrst)
        fault |=> hold_cnt == 32'h0)
        else $error("hold timer not restarted");

    // Manual reset wins over every alarm source
    AST_MR_ALARM_HIGH: assert property (@(posedge clk) disable iff (!nrst)
        !mr_n |=> dog_alarm_n && dog_cnt == 32'h0)
        else $error("manual reset fault");

    // An expired period with no kick pulls the alarm low
    AST_TIMEOUT_ALARM: assert property (@(posedge clk) disable iff (!nrst)
        (mr_n && supply_good && !holding && !kick_edge && dog_limit_hit) |=> !dog_alarm_n)
        else $error("timeout without alarm");

    // In short mode the counter never runs past the short limit, so no timeout can be skipped
    AST_SHORT_BOUND: assert property (@(posedge clk) disable iff (!nrst)
        dog_mode == SRW_SHORT |-> dog_cnt < 32'(SHORT_TICKS))
        else $error("short period counter overran");

    // Any reset or hold puts the watchdog back into long mode
    AST_LONG_AFTER_RESET: assert property (@(posedge clk) disable iff (!nrst)
        (fault || holding) |=> dog_mode == SRW_LONG)
        else $error("not long mode");

    // First accepted kick starts the short period
    AST_SHORT_ON_KICK: assert property (@(posedge clk) disable iff (!nrst)
        (!fault && !holding && kick_edge) |=> dog_mode == SRW_SHORT && dog_cnt == 32'h0)
        else $error("kick did not restart short period");

    // An accepted kick also lets go of a standing alarm
    AST_KICK_CLEARS_ALARM: assert property (@(posedge clk) disable iff (!nrst)
        (!fault && !holding && kick_edge) |=> dog_alarm_n)
        else $error("kick left alarm low");

    // A missed kick in short mode alarms and stays in short mode
    AST_SHORT_TIMEOUT: assert property (@(posedge clk) disable iff (!nrst)
        (!fault && !holding && !kick_edge && dog_limit_hit && dog_mode == SRW_SHORT)
        |=> !dog_alarm_n && dog_mode == SRW_SHORT)
        else $error("short timeout missed");

    // Alarm fed back as manual reset gives a reset and lets go of the alarm
    AST_FEEDBACK_RESET: assert property (@(posedge clk) disable iff (!nrst)
        !mr_n |=> !reset_out_n && dog_alarm_n && dog_mode == SRW_LONG)
        else $error("alarm feedback did not reset");

    // Watchdog leaves the hold cleared and in long mode
    AST_LONG_AT_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
        $rose(reset_out_n) |-> $past(dog_mode) == SRW_LONG && $past(dog_cnt) == 32'h0)
        else $error("watchdog not long at release");

    // Reset output low means the watchdog counter is held clear
    AST_RESET_CLEARS_DOG: assert property (@(posedge clk) disable iff (!nrst)
        !reset_out_n |-> dog_cnt == 32'h0)
        else $error("counter running in reset");

    // Lockout pulls the alarm low unless manual reset holds it high
    AST_LOCKOUT_ALARM: assert property (@(posedge clk) disable iff (!nrst)
        (mr_n && !supply_good) |=> !dog_alarm_n)
        else $error("lockout alarm missing");

    // Lockout alarm lets go while the reset hold is still running
    AST_UVLO_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
        (mr_n && supply_good && holding) |=> dog_alarm_n)
        else $error("alarm held through reset hold");

    // A tick comes only after a full prescaler period since the last restart
    AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
        tick |-> $past(pre_cnt) == 32'(TICK_CYC - 1))
        else $error("tick out of step with prescaler");

    // Reset lifts only after the hold counter reached its end
    AST_RELEASE_ORDER: assert property (@(posedge clk) disable iff (!nrst)
        $rose(reset_out_n) |-> $past(hold_cnt) == 32'(HOLD_TICKS))
        else $error("reset released before full hold");
endmodule : srw_top

// *** verif/srw_host_model.sv ***
// Host processor model: toggles the kick line at a set gap while running.
// Assumes the bench drives its controls at the falling clock edge.
module srw_host_model (
    input wire logic clk,
    input wire logic reset_out_n,
    input wire logic kick_en,
    input wire logic [7:0] gap,
    output logic dog_kick_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    // Kick well inside the short period; silent while held in reset
    initial begin
        dog_kick_in = 1'b0;
        cnt = 8'h00;
        forever begin
            @(negedge clk);
            if (!reset_out_n || !kick_en) begin
                cnt = 8'h00;
            end else if (cnt >= gap) begin
                cnt = 8'h00;
                dog_kick_in = ~dog_kick_in;
            end else begin
                cnt = cnt + 8'h01;
            end
        end
    end
endmodule : srw_host_model

// *** verif/supervisor_reset_watchdog_tb.sv ***
// Self-checking bench for the supervisor sequencer with short tick counts.
// Assumes tick of 4 cycles, hold 3, long 20 and short 5 ticks.
module supervisor_reset_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import srw_pkg::*;
    logic clk, nrst, man_n, fb_en, kick_en, reset_out_n, dog_alarm_n, dog_kick_in;
    logic manual_reset_n;
    logic [7:0] gap;
    srw_supply_t supply;
    srw_mode_t dog_mode;
    int num_errors, num_checks, c;
    // Feedback path lets the alarm pull the manual reset input
    assign manual_reset_n = fb_en ? dog_alarm_n : man_n;
    srw_top #(.TICK_CYC(4), .HOLD_TICKS(3), .LONG_TICKS(20), .SHORT_TICKS(5)) uut (
        .clk(clk), .nrst(nrst), .supply(supply), .manual_reset_n(manual_reset_n),
        .dog_kick_in(dog_kick_in), .reset_out_n(reset_out_n), .dog_alarm_n(dog_alarm_n),
        .dog_mode(dog_mode));
    srw_host_model host (.clk(clk), .reset_out_n(reset_out_n), .kick_en(kick_en),
        .gap(gap), .dog_kick_in(dog_kick_in));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk
    // Bounded wait for a level on reset or alarm; a timeout ends the run
    task automatic wait_for(input bit on_alarm, input logic lvl, input int lim, output int n);
        n = 0;
        while (((on_alarm ? dog_alarm_n : reset_out_n) !== lvl) && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            num_errors++;
            $display("[FAIL] wait expected %b seen timeout", lvl);
            end_of_test();
        end
    endtask : wait_for
    task automatic t_supply();
        for (int i = 0; i < 3; i++) begin
            supply = 3'h7 ^ (3'h1 << i);
            @(negedge clk);
            chk("rst_fault", 1'b0, reset_out_n);
            chk("alarm_uvlo", 1'b0, dog_alarm_n);
            supply = 3'h7;
            @(negedge clk);
            chk("alarm_free", 1'b1, dog_alarm_n);
            repeat (8) @(negedge clk);
            supply = 3'h7 ^ (3'h1 << i);
            @(negedge clk);
            supply = 3'h7;
            wait_for(0, 1'b1, 30, c);
            chk("hold_restart", 1'b1, c >= 13);
        end
    endtask : t_supply
    // Power-on, long expiry, kicking, manual reset and alarm feedback
    initial begin
        num_errors = 0;
        num_checks = 0;
        nrst = 1'b0;
        man_n = 1'b1;
        fb_en = 1'b0;
        kick_en = 1'b0;
        gap = 8'h09;
        supply = 3'h7;
        repeat (10) @(negedge clk);
        chk("por_rst", 1'b0, reset_out_n);
        chk("por_alarm", 1'b1, dog_alarm_n);
        chk("por_mode", 1'b0, dog_mode);
        nrst = 1'b1;
        wait_for(0, 1'b1, 30, c);
        chk("hold_len", 1'b1, c >= 13);
        wait_for(1, 1'b0, 100, c);
        chk("long_len", 1'b1, c >= 70);
        chk("long_to_short", 1'b1, dog_mode);
        kick_en = 1'b1;
        wait_for(1, 1'b1, 20, c);
        c = 0;
        repeat (100) begin
            @(negedge clk);
            c += (dog_alarm_n !== 1'b1);
        end
        chk("kicked_ok", 1'b1, c == 0);
        kick_en = 1'b0;
        wait_for(1, 1'b0, 40, c);
        chk("short_len", 1'b1, c >= 16);
        t_supply();
        man_n = 1'b0;
        kick_en = 1'b1;
        repeat (20) @(negedge clk);
        chk("man_rst", 1'b0, reset_out_n);
        chk("man_alarm", 1'b1, dog_alarm_n);
        chk("man_mode", 1'b0, dog_mode);
        man_n = 1'b1;
        wait_for(0, 1'b1, 40, c);
        chk("hold_mode", 1'b0, dog_mode);
        repeat (15) @(negedge clk);
        chk("first_kick", 1'b1, dog_mode);
        kick_en = 1'b0;
        fb_en = 1'b1;
        wait_for(1, 1'b0, 40, c);
        wait_for(1, 1'b1, 8, c);
        chk("fb_rst", 1'b0, reset_out_n);
        wait_for(0, 1'b1, 40, c);
        chk("fb_mode", 1'b0, dog_mode);
        end_of_test();
    end
endmodule : supervisor_reset_watchdog_tb
